// File: include/dat_pkg.sv
package dat_pkg;
  // prescaler divide default: 20 MHz core clock gives a one-second tick
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned DIV_DEFAULT = CLK_HZ * TICK_S;
  localparam int DIV_W = 25;
  // pattern timing in whole seconds
  localparam logic [2:0] SHORT_ON_S = 3'h1;
  localparam logic [2:0] SHORT_OFF_S = 3'h1;
  localparam logic [2:0] LONG_ON_S = 3'h3;
  localparam logic [2:0] LONG_OFF_S = 3'h1;
  localparam logic [2:0] SPARE_ON_S = 3'h1;
  localparam logic [2:0] SPARE_OFF_S = 3'h3;
  localparam logic [2:0] DONE_ON_S = 3'h2;
  // completion tone toggles every 4096 core cycles, on this bit select of the warble counter (warble)
  localparam int DONE_WARBLE_BIT = 12;
  // led pulse length in core cycles
  localparam logic [15:0] LED_PULSE_CYC = 16'h2710;

  typedef enum logic [2:0] {
    DAT_PAT_NONE = 3'b000,
    DAT_PAT_FAILED = 3'b001,
    DAT_PAT_REBUILD = 3'b010,
    DAT_PAT_DEGRADED = 3'b011,
    DAT_PAT_SPARE = 3'b100,
    DAT_PAT_DONE = 3'b101
  } dat_pat_t;
endpackage : dat_pkg

// File: rtl/dat_tick.sv
`timescale 1ns/10ps
// one-second tick prescaler; restart realigns the phase
module dat_tick (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic [dat_pkg::DIV_W-1:0] div_value,
  output logic tick
);
  import dat_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } dat_tick_state_t;

  dat_tick_state_t st;
  dat_tick_state_t next_st;

  // count up to the divide; zero or one ticks every cycle
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.cnt = '0;
    end else if (st.cnt + 1'b1 >= div_value) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : dat_tick

// File: rtl/dat_alarm.sv
`timescale 1ns/10ps
// Summary of operation
// RL1: degraded array sounds one second on, one second off, repeating.
// RL2: failed array sounds three seconds on, one second off, repeating.
// RL3: commissioned hot spare sounds one second on, three seconds off.
// RL4: failure pattern repeats until cleared, silenced or disabled.
// RL5: silence is temporary; new failure or reset with fault resumes it.
// RL6: disable persists through errors and resets until re-enabled.
// RL7: rebuild in progress keeps the sounder continuously on.
// RL8: rebuild completion plays a distinct warbling tone.
// RL9: completion tone plays once per completion event only.
// RL10: LED pulses on adapter activity, dark when idle.
// RL11: priority is failed, rebuild, degraded, then hot spare.
// RL12: seconds come from a configurable prescaler; pattern change restarts.
module dat_alarm (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [dat_pkg::DIV_W-1:0] div_value,
  input wire logic degraded_in,
  input wire logic failed_in,
  input wire logic spare_in,
  input wire logic rebuild_in,
  input wire logic rebuild_done_in,
  input wire logic activity_in,
  input wire logic silence_req,
  input wire logic disable_req,
  input wire logic enable_req,
  input wire logic disable_keep,
  output logic sounder,
  output logic led,
  output logic alarm_disabled,
  output logic alarm_silenced,
  output dat_pkg::dat_pat_t pattern
);
  import dat_pkg::*;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] prev;
    logic silenced;
    logic disabled;
    logic done_pend;
    logic started;
    dat_pat_t pat;
    logic [2:0] sec;
    logic on_phase;
    logic sounder;
    logic [15:0] led_cnt;
    logic led;
    logic [DONE_WARBLE_BIT:0] warble;
  } dat_state_t;

  dat_state_t st;
  dat_state_t next_st;
  logic tick;
  logic restart;
  logic [5:0] in_raw;
  logic [5:0] lv;
  logic [5:0] rise;
  dat_pat_t want;

  // on and off lengths of each pulsing pattern
  function automatic logic [2:0] on_len(input dat_pat_t p);
    case (p)
      DAT_PAT_FAILED: on_len = LONG_ON_S;
      DAT_PAT_DEGRADED: on_len = SHORT_ON_S;
      DAT_PAT_SPARE: on_len = SPARE_ON_S;
      DAT_PAT_DONE: on_len = DONE_ON_S;
      default: on_len = 3'h1;
    endcase
  endfunction : on_len

  function automatic logic [2:0] off_len(input dat_pat_t p);
    case (p)
      DAT_PAT_FAILED: off_len = LONG_OFF_S;
      DAT_PAT_DEGRADED: off_len = SHORT_OFF_S;
      DAT_PAT_SPARE: off_len = SPARE_OFF_S;
      default: off_len = 3'h1;
    endcase
  endfunction : off_len

  // pins come from outside the clock domain
  assign in_raw = {activity_in, rebuild_done_in, rebuild_in, spare_in,
                   failed_in, degraded_in};
  assign lv = st.sync2;
  assign rise = st.sync2 & ~st.prev;

  // RL11 pattern priority select
  always_comb begin
    if (st.disabled) begin
      want = DAT_PAT_NONE;
    end else if (lv[1] && !st.silenced) begin
      want = DAT_PAT_FAILED;
    end else if (lv[3]) begin
      want = DAT_PAT_REBUILD;
    end else if (lv[0] && !st.silenced) begin
      want = DAT_PAT_DEGRADED;
    end else if (lv[2] && !st.silenced) begin
      want = DAT_PAT_SPARE;
    end else if (st.done_pend || st.pat == DAT_PAT_DONE) begin
      want = DAT_PAT_DONE;
    end else begin
      want = DAT_PAT_NONE;
    end
  end

  // RL12 phase restarts on any pattern change
  assign restart = (want != st.pat);

  dat_tick u_tick (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .restart(restart),
    .div_value(div_value),
    .tick(tick)
  );

  // next state of the whole sequencer
  always_comb begin
    next_st = st;
    next_st.sync1 = in_raw;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.started = 1'b1;
    // RL5 a fresh failure lifts the silence; clear wins over silence request
    if (silence_req) begin
      next_st.silenced = 1'b1;
    end
    if (|rise[2:0]) begin
      next_st.silenced = 1'b0;
    end
    // RL6 disable held until an explicit enable
    if (disable_req) begin
      next_st.disabled = 1'b1;
    end else if (enable_req) begin
      next_st.disabled = 1'b0;
    end
    // RL6 after reset take the persistent setting from storage
    if (!st.started) begin
      next_st.disabled = disable_keep;
    end
    // RL9 one completion tone per rising edge of done
    if (rise[4]) begin
      next_st.done_pend = 1'b1;
    end else if (st.pat == DAT_PAT_DONE) begin
      next_st.done_pend = 1'b0;
    end
    next_st.pat = want;
    if (restart) begin
      next_st.sec = '0;
      next_st.on_phase = 1'b1;
    end else if (tick) begin
      // RL4 pulsing patterns cycle while the condition holds
      if (st.on_phase && st.sec + 3'h1 >= on_len(st.pat)) begin
        next_st.sec = '0;
        next_st.on_phase = 1'b0;
        if (st.pat == DAT_PAT_DONE) begin
          // RL9 completion tone ends here, never repeats
          next_st.pat = DAT_PAT_NONE;
        end
      end else if (!st.on_phase && st.sec + 3'h1 >= off_len(st.pat)) begin
        next_st.sec = '0;
        next_st.on_phase = 1'b1;
      end else begin
        next_st.sec = st.sec + 3'h1;
      end
    end
    // warble restarts with the pattern so the completion tone opens high;
    // an on phase shorter than half the warble period leaves the tone steady
    if (restart) begin
      next_st.warble = '0;
    end else begin
      next_st.warble = st.warble + 1'b1;
    end
    // sounder output per pattern
    case (next_st.pat)
      // RL1 RL2 RL3 pulsed tones
      DAT_PAT_FAILED, DAT_PAT_DEGRADED, DAT_PAT_SPARE: begin
        next_st.sounder = next_st.on_phase;
      end
      // RL7 rebuild steady on
      DAT_PAT_REBUILD: begin
        next_st.sounder = 1'b1;
      end
      // RL8 warble sets it apart from the steady and pulsed tones
      DAT_PAT_DONE: begin
        next_st.sounder = next_st.on_phase & ~next_st.warble[DONE_WARBLE_BIT];
      end
      default: begin
        next_st.sounder = 1'b0;
      end
    endcase
    // RL10 retriggered led pulse on activity
    if (lv[5]) begin
      next_st.led_cnt = LED_PULSE_CYC;
      next_st.led = 1'b1;
    end else if (st.led_cnt != '0) begin
      next_st.led_cnt = st.led_cnt - 16'h0001;
      next_st.led = 1'b1;
    end else begin
      next_st.led = 1'b0;
    end
  end

  // reset clears silence (RL5) but disable reloads from disable_keep
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sounder = st.sounder;
  assign led = st.led;
  assign alarm_disabled = st.disabled;
  assign alarm_silenced = st.silenced;
  assign pattern = st.pat;

  // checks, all on the core clock and quiet during reset
  // RL7 rebuild steady on
  chk_rebuild_steady: assert property ( // RL7
    @(posedge core_clk) disable iff (!nrst)
    clk_en && st.pat == DAT_PAT_REBUILD && next_st.pat == DAT_PAT_REBUILD
    |=> sounder)
    else $error("rebuild tone not steady");
  // RL6 disabled stays quiet
  chk_disabled_quiet: assert property ( // RL6
    @(posedge core_clk) disable iff (!nrst)
    clk_en && st.disabled |=> pattern == DAT_PAT_NONE && !sounder)
    else $error("tone while disabled");
  // RL6 disable kept until enable
  chk_disable_kept: assert property ( // RL6
    @(posedge core_clk) disable iff (!nrst)
    clk_en && st.disabled && st.started && !enable_req |=> alarm_disabled)
    else $error("disable lost without enable");
  // RL11 failed array first
  chk_failed_first: assert property ( // RL11
    @(posedge core_clk) disable iff (!nrst)
    clk_en && lv[1] && !st.silenced && !st.disabled
    |=> pattern == DAT_PAT_FAILED)
    else $error("failed array not top priority");
  // RL11 rebuild over degraded
  chk_rebuild_over: assert property ( // RL11
    @(posedge core_clk) disable iff (!nrst)
    clk_en && lv[3] && !lv[1] && !st.disabled
    |=> pattern == DAT_PAT_REBUILD)
    else $error("rebuild not over degraded");
  // RL5 fresh failure unsilences
  chk_fresh_fail: assert property ( // RL5
    @(posedge core_clk) disable iff (!nrst)
    clk_en && |rise[2:0] |=> !alarm_silenced)
    else $error("new failure kept silence");
  // RL12 phase restart on change
  chk_pattern_restart: assert property ( // RL12
    @(posedge core_clk) disable iff (!nrst)
    clk_en && restart |=> st.sec == 3'h0 && st.on_phase)
    else $error("phase not restarted");
  // RL10 led lit on activity
  chk_led_active: assert property ( // RL10
    @(posedge core_clk) disable iff (!nrst)
    clk_en && lv[5] |=> led)
    else $error("led dark on activity");
  // RL10 led dark when idle
  chk_led_dark: assert property ( // RL10
    @(posedge core_clk) disable iff (!nrst)
    clk_en && !lv[5] && st.led_cnt == '0 |=> !led)
    else $error("led lit while idle");
  // RL4 silence request taken
  chk_silence_hold: assert property ( // RL4
    @(posedge core_clk) disable iff (!nrst)
    clk_en && silence_req && !(|rise[2:0]) |=> alarm_silenced)
    else $error("silence request ignored");
  // RL4 silence stops failure tones
  chk_silence_mutes: assert property ( // RL4
    @(posedge core_clk) disable iff (!nrst)
    clk_en && st.silenced && !lv[3] && !st.done_pend
    && st.pat != DAT_PAT_DONE |=> pattern == DAT_PAT_NONE)
    else $error("failure tone while silenced");
  // RL9 completion tone once
  chk_done_once: assert property ( // RL9
    @(posedge core_clk) disable iff (!nrst)
    clk_en && st.pat == DAT_PAT_DONE && next_st.pat == DAT_PAT_NONE
    && !rise[4] |=> !st.done_pend)
    else $error("completion tone rearmed");
  // RL8 completion tone starts
  chk_done_tone: assert property ( // RL8
    @(posedge core_clk) disable iff (!nrst)
    clk_en && restart && want == DAT_PAT_DONE
    |=> pattern == DAT_PAT_DONE && sounder)
    else $error("completion tone silent");
  // RL1 one second on
  chk_degraded_on: assert property ( // RL1
    @(posedge core_clk) disable iff (!nrst)
    clk_en && tick && !restart && st.pat == DAT_PAT_DEGRADED && st.on_phase
    && st.sec == SHORT_ON_S - 3'h1 |=> !sounder)
    else $error("degraded on phase too long");
  // RL2 three seconds on
  chk_failed_long: assert property ( // RL2
    @(posedge core_clk) disable iff (!nrst)
    clk_en && tick && !restart && st.pat == DAT_PAT_FAILED && st.on_phase
    && st.sec != LONG_ON_S - 3'h1 |=> sounder)
    else $error("failed on phase too short");
  // RL3 three seconds off
  chk_spare_off: assert property ( // RL3
    @(posedge core_clk) disable iff (!nrst)
    clk_en && tick && !restart && st.pat == DAT_PAT_SPARE && !st.on_phase
    && st.sec != SPARE_OFF_S - 3'h1 |=> !sounder)
    else $error("spare off phase too short");

  cov_failed: cover property (@(posedge core_clk) pattern == DAT_PAT_FAILED);
  cov_spare: cover property (@(posedge core_clk) pattern == DAT_PAT_SPARE);
  cov_done: cover property (@(posedge core_clk) pattern == DAT_PAT_DONE);
  cov_silenced: cover property (@(posedge core_clk) alarm_silenced && lv[1]);
  cov_rebuild: cover property (@(posedge core_clk)
    pattern == DAT_PAT_REBUILD);
endmodule : dat_alarm

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
  import dat_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic clk_en = 1'h1;
  logic [DIV_W-1:0] div_value = '0;
  logic [3:0] fault = 4'h0;
  logic rebuild_done_in = 1'h0, activity_in = 1'h0;
  logic silence_req = 1'h0, disable_req = 1'h0, enable_req = 1'h0;
  logic disable_keep = 1'h0;
  logic sounder, led, alarm_disabled, alarm_silenced;
  dat_pat_t pattern;
  wire degraded_in = fault[0];
  wire failed_in = fault[1];
  wire spare_in = fault[2];
  wire rebuild_in = fault[3];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int d;
  // a long second lets the completion warble show within one tone
  localparam int DONE_DIV = 1 << (DONE_WARBLE_BIT + 1);
  logic [5:0] n;
  logic [5:0] note_q[$];

  // 50 ns period
  always #25 core_clk = ~core_clk;

  dat_alarm i_dat_alarm (.core_clk, .nrst, .clk_en, .div_value,
    .degraded_in, .failed_in, .spare_in, .rebuild_in, .rebuild_done_in,
    .activity_in, .silence_req, .disable_req, .enable_req, .disable_keep,
    .sounder, .led, .alarm_disabled, .alarm_silenced, .pattern);

  task automatic wrap_up;
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // hang guard, the whole run needs about 28000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  // kinds: 0 pattern, 1 sounder, 2 led, 3 disabled, 4 silenced
  task automatic note(input logic [2:0] k, input logic [2:0] v);
    note_q.push_back({k, v});
  endtask : note

  task automatic chk_pat(input logic [2:0] e);
    samples_checked++;
    if (pattern !== dat_pat_t'(e)) begin
      err_count++;
      $display("unexpected at %0t: pattern %0h not %0h", $time, pattern, e);
    end
  endtask : chk_pat

  task automatic chk_bit(input string s, input logic a, input logic e);
    samples_checked++;
    if (a !== e) begin
      err_count++;
      $display("unexpected at %0t: %s is %b not %b", $time, s, a, e);
    end
  endtask : chk_bit

  // notes are judged a few ns after the falling edge, outputs settled
  always begin
    @(negedge core_clk);
    #5;
    while (note_q.size() > 0) begin
      n = note_q.pop_front();
      case (n[5:3])
        3'h0: chk_pat(n[2:0]);
        3'h1: chk_bit("sounder", sounder, n[0]);
        3'h2: chk_bit("led", led, n[0]);
        3'h3: chk_bit("disabled", alarm_disabled, n[0]);
        default: chk_bit("silenced", alarm_silenced, n[0]);
      endcase
    end
  end

  task automatic wait_pat(input dat_pat_t p);
    for (int i = 0; i < 20 && pattern !== p; i++) cyc(1);
    note(3'h0, p);
  endtask : wait_pat

  task automatic wait_snd;
    for (int i = 0; i < 6 * d && sounder !== 1'h1; i++) cyc(1);
    note(3'h1, 3'h1);
  endtask : wait_snd

  // samples mid-phase so a one-cycle tick skew cannot matter
  task automatic tone(input int on, input int off);
    cyc(d / 2);
    for (int k = 0; k < 2 * (on + off); k++) begin
      note(3'h1, 3'((k % (on + off)) < on));
      cyc(d);
    end
  endtask : tone

  task automatic steady(input logic v, input int k);
    repeat (k) begin
      note(3'h1, 3'(v));
      cyc(d);
    end
  endtask : steady

  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    cyc(4);
  endtask : pulse

  task automatic rst;
    nrst = 1'h0;
    cyc(3);
    nrst = 1'h1;
  endtask : rst

  task automatic run_pat(input logic [3:0] f, input dat_pat_t p,
                         input int on, input int off);
    fault = f;
    wait_pat(p);
    tone(on, off);
    fault = 4'h0;
    wait_pat(DAT_PAT_NONE);
    $display("test pattern %0d done", p);
  endtask : run_pat

  initial begin
    void'($urandom(4786));
    d = 8 + $urandom_range(4);
    div_value = DIV_W'(d);
    cyc(1);
    note(3'h0, 3'h0);
    note(3'h1, 3'h0);
    note(3'h2, 3'h0);
    cyc(2);
    nrst = 1'h1;
    $display("test reset done");
    run_pat(4'h1, DAT_PAT_DEGRADED, 1, 1);
    run_pat(4'h2, DAT_PAT_FAILED, 3, 1);
    run_pat(4'h4, DAT_PAT_SPARE, 1, 3);
    fault = 4'hF;
    wait_pat(DAT_PAT_FAILED);
    fault = 4'hD;
    wait_pat(DAT_PAT_REBUILD);
    steady(1'h1, 3);
    pulse(silence_req);
    note(3'h4, 3'h1);
    steady(1'h1, 4);
    fault = 4'h5;
    cyc(6);
    note(3'h0, 3'h0);
    fault = 4'h0;
    cyc(4);
    fault = 4'h5;
    wait_pat(DAT_PAT_DEGRADED);
    fault = 4'h4;
    wait_pat(DAT_PAT_SPARE);
    fault = 4'h0;
    cyc(6);
    $display("test priority done");
    fault = 4'h2;
    wait_pat(DAT_PAT_FAILED);
    clk_en = 1'h0;
    fault = 4'h0;
    cyc(6);
    note(3'h0, 3'(DAT_PAT_FAILED));
    note(3'h1, 3'h1);
    fault = 4'h2;
    clk_en = 1'h1;
    pulse(silence_req);
    note(3'h4, 3'h1);
    steady(1'h0, 5);
    fault = 4'h6;
    cyc(5);
    note(3'h4, 3'h0);
    wait_snd();
    pulse(silence_req);
    rst();
    wait_pat(DAT_PAT_FAILED);
    cyc(2);
    note(3'h4, 3'h0);
    note(3'h1, 3'h1);
    $display("test silence done");
    disable_keep = 1'h1;
    pulse(disable_req);
    note(3'h3, 3'h1);
    fault = 4'h2;
    cyc(4);
    fault = 4'h6;
    steady(1'h0, 4);
    rst();
    cyc(2);
    note(3'h3, 3'h1);
    steady(1'h0, 4);
    disable_keep = 1'h0;
    pulse(enable_req);
    note(3'h3, 3'h0);
    wait_snd();
    $display("test disable done");
    fault = 4'h8;
    wait_pat(DAT_PAT_REBUILD);
    div_value = DIV_W'(DONE_DIV);
    fault = 4'h0;
    rebuild_done_in = 1'h1;
    wait_pat(DAT_PAT_DONE);
    note(3'h1, 3'h1);
    cyc(DONE_DIV / 2 + DONE_DIV / 4);
    note(3'h1, 3'h0);
    cyc(DONE_DIV + DONE_DIV / 4 + 6);
    note(3'h0, 3'h0);
    div_value = DIV_W'(d);
    steady(1'h0, 6);
    note(3'h0, 3'h0);
    rebuild_done_in = 1'h0;
    $display("test completion done");
    note(3'h2, 3'h0);
    activity_in = 1'h1;
    cyc(1 + $urandom_range(3));
    activity_in = 1'h0;
    cyc(4);
    note(3'h2, 3'h1);
    cyc(int'(LED_PULSE_CYC) + d);
    note(3'h2, 3'h0);
    cyc(2);
    $display("test activity done");
    wrap_up();
  end
endmodule : tb
